//--- design/gtfm_core.sv
// Gate fault, thermal and offline diagnostic manager of a half-bridge driver.
// Assumes synchronous inputs; register fields arrive as plain ports.
`timescale 1ns/10ps
`include "gtfm_defines.svh"
module gtfm_core
  import gtfm_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic        hw_variant_i,
  input  wire logic [2:0]  hw_cfg_level_i,
  input  wire logic [1:0]  gate_fault_mode_sel_i,
  input  wire logic        gate_fault_local_shutdown_i,
  input  wire logic [1:0]  bridge_ctrl_mode_i,
  input  wire logic [`GTFM_CNT_W-1:0] gate_drive_timeout_i,
  input  wire logic        clear_faults_cmd_i,
  input  wire logic        driver_enable_bit_i,
  input  wire logic        driver_off_in_i,
  input  wire logic [1:0]  gate_drive_on_i,
  input  wire logic [1:0]  gate_level_ok_i,
  input  wire logic [1:0]  pwm_in_i,
  input  wire logic        overtemp_warn_i,
  input  wire logic        overtemp_shutdown_i,
  input  wire logic        offline_diag_enable_i,
  input  wire logic [1:0]  node_pullup_src_en_i,
  input  wire logic [1:0]  node_pulldown_src_en_i,
  input  wire logic [1:0]  ds_comparator_i,
  output logic             fault_out_n_o,
  output logic             fault_summary_o,
  output logic             warn_summary_o,
  output logic [1:0]       gate_fault_flag_o,
  output logic             overtemp_warn_flag_o,
  output logic             overtemp_shutdown_flag_o,
  output logic [1:0]       drain_source_flag_o,
  output logic [1:0]       gate_pulldown_o,
  output logic             charge_pump_en_o,
  output logic [1:0]       node_pullup_on_o,
  output logic [1:0]       node_pulldown_on_o,
  output logic             clear_faults_ack_o
);

  // ==========================================================================
  // Effective configuration
  // ==========================================================================
  logic [1:0] mode_eff;
  logic       local_eff;
  logic [`GTFM_CNT_W-1:0] timeout_eff;
  logic       diag_ok;
  logic       clr;

  always_comb begin
    if (hw_variant_i) begin
      mode_eff = (hw_cfg_level_i == `GTFM_LVL_GDF_OFF) ?
                 `GTFM_MODE_DIS : `GTFM_MODE_CYCLE;
      local_eff   = 1'b1;
      timeout_eff = `GTFM_CNT_W'(`GTFM_GATE_DRIVE_TIMEOUT_HW_CYC);
    end else begin
      mode_eff    = gate_fault_mode_sel_i;
      local_eff   = gate_fault_local_shutdown_i;
      timeout_eff = gate_drive_timeout_i;
    end
  end

  assign clr     = clear_faults_cmd_i && !hw_variant_i;
  assign diag_ok = offline_diag_enable_i && !hw_variant_i;
  assign clear_faults_ack_o = clr;

  // ==========================================================================
  // Per half-bridge gate fault detection and response
  // ==========================================================================
  logic [1:0] detect;
  logic [1:0] active_q;
  logic [1:0] flag_q;
  logic [1:0] pwm_q;
  logic [1:0] warn_gdf_q;
  logic       bridge_local;

  assign bridge_local = local_eff &&
    (bridge_ctrl_mode_i == `GTFM_BRG_INDEP ||
     bridge_ctrl_mode_i == `GTFM_BRG_SPLIT);

  always_ff @(posedge clk_i) begin
    if (reset_i)
      pwm_q <= 2'h0;
    else
      pwm_q <= pwm_in_i;
  end

  genvar g;
  generate
    for (g = 0; g < `GTFM_NBR; g++) begin : g_br
      logic [`GTFM_CNT_W-1:0] cnt_q;
      gtfm_state_t st_q;

      // Timeout counter runs while gate driven but below level
      always_ff @(posedge clk_i) begin
        if (reset_i || !gate_drive_on_i[g] || gate_level_ok_i[g])
          cnt_q <= '0;
        else if (cnt_q <= timeout_eff)
          cnt_q <= cnt_q + `GTFM_CNT_W'(1);
      end
      assign detect[g] = (cnt_q > timeout_eff) &&
                         (mode_eff != `GTFM_MODE_DIS);

      always_ff @(posedge clk_i) begin
        if (reset_i)
          st_q <= GTFM_ST_RUN;
        else begin
          case (st_q)
            GTFM_ST_RUN: begin
              if (detect[g] && mode_eff == `GTFM_MODE_LATCH)
                st_q <= GTFM_ST_HOLD;
              else if (detect[g] && mode_eff == `GTFM_MODE_CYCLE)
                st_q <= GTFM_ST_FLT;
            end
            GTFM_ST_FLT: begin
              if (pwm_in_i[g] != pwm_q[g] && !detect[g])
                st_q <= GTFM_ST_RUN;
            end
            GTFM_ST_HOLD: begin
              if (clr)
                st_q <= GTFM_ST_RUN;
            end
            default: st_q <= GTFM_ST_RUN;
          endcase
        end
      end
      assign active_q[g] = (st_q != GTFM_ST_RUN);

      // Reported flag: set wins over clear
      always_ff @(posedge clk_i) begin
        if (reset_i)
          flag_q[g] <= 1'b0;
        else if (detect[g])
          flag_q[g] <= 1'b1;
        else if (clr)
          flag_q[g] <= 1'b0;
      end

      always_ff @(posedge clk_i) begin
        if (reset_i)
          warn_gdf_q[g] <= 1'b0;
        else if (detect[g] && mode_eff == `GTFM_MODE_WARN)
          warn_gdf_q[g] <= 1'b1;
        else if (clr)
          warn_gdf_q[g] <= 1'b0;
      end
    end
  endgenerate

  // ==========================================================================
  // Thermal warning and shutdown
  // ==========================================================================
  logic otw_q;
  logic overtemp_shutdown_flag_q;
  logic overtemp_shutdown_flag_act;

  always_ff @(posedge clk_i) begin
    if (reset_i)
      otw_q <= 1'b0;
    else if (overtemp_warn_i && !hw_variant_i)
      otw_q <= 1'b1;
    else if (clr)
      otw_q <= 1'b0;
  end

  always_ff @(posedge clk_i) begin
    if (reset_i)
      overtemp_shutdown_flag_q <= 1'b0;
    else if (overtemp_shutdown_i)
      overtemp_shutdown_flag_q <= 1'b1;
    else if (clr || hw_variant_i)
      overtemp_shutdown_flag_q <= 1'b0;
  end
  assign overtemp_shutdown_flag_act = overtemp_shutdown_flag_q || overtemp_shutdown_i;

  // ==========================================================================
  // Offline diagnostics
  // ==========================================================================
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      node_pullup_on_o   <= 2'h0;
      node_pulldown_on_o <= 2'h0;
    end else begin
      node_pullup_on_o   <= diag_ok ? node_pullup_src_en_i : 2'h0;
      node_pulldown_on_o <= diag_ok ? node_pulldown_src_en_i : 2'h0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i)
      drain_source_flag_o <= 2'h0;
    else if (diag_ok)
      drain_source_flag_o <= ds_comparator_i;
    else if (clr)
      drain_source_flag_o <= 2'h0;
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  logic       any_fault;
  logic [1:0] pd_d;
  logic       drv_off;

  assign any_fault = (|active_q) || overtemp_shutdown_flag_act;
  assign drv_off   = driver_off_in_i ||
                     (!driver_enable_bit_i && !hw_variant_i);

  always_comb begin
    for (int i = 0; i < `GTFM_NBR; i++) begin
      pd_d[i] = overtemp_shutdown_flag_act || drv_off ||
                (bridge_local ? active_q[i] : (|active_q));
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      gate_pulldown_o          <= 2'h3;
      charge_pump_en_o         <= 1'b0;
      fault_summary_o          <= 1'b0;
      fault_out_n_o            <= 1'b1;
      warn_summary_o           <= 1'b0;
      gate_fault_flag_o        <= 2'h0;
      overtemp_warn_flag_o     <= 1'b0;
      overtemp_shutdown_flag_o <= 1'b0;
    end else begin
      gate_pulldown_o          <= pd_d;
      charge_pump_en_o         <= !overtemp_shutdown_flag_act;
      fault_summary_o          <= any_fault;
      fault_out_n_o            <= !any_fault;
      warn_summary_o           <= otw_q || (|warn_gdf_q);
      gate_fault_flag_o        <= flag_q;
      overtemp_warn_flag_o     <= otw_q;
      overtemp_shutdown_flag_o <= overtemp_shutdown_flag_q;
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  property p_latch_hold;
    @(posedge clk_i) disable iff (reset_i)
      (detect[0] && mode_eff == `GTFM_MODE_LATCH && !clr) |=>
        ##1 (!fault_out_n_o && fault_summary_o);
  endproperty
  a_latch_hold: assert property (p_latch_hold)
    else $error("latched gate fault not reported");

  property p_disabled;
    @(posedge clk_i) disable iff (reset_i)
      (mode_eff == `GTFM_MODE_DIS) |=>
        ((flag_q & ~$past(flag_q)) == 2'h0 &&
         (warn_gdf_q & ~$past(warn_gdf_q)) == 2'h0);
  endproperty
  a_disabled: assert property (p_disabled)
    else $error("disabled mode detected a fault");

  property p_warn_only;
    @(posedge clk_i) disable iff (reset_i)
      ((|detect) && mode_eff == `GTFM_MODE_WARN) |=> ##1 warn_summary_o;
  endproperty
  a_warn_only: assert property (p_warn_only)
    else $error("warning mode did not set warn summary");

  property p_otw;
    @(posedge clk_i) disable iff (reset_i)
      (overtemp_warn_i && !hw_variant_i) |=> ##1 overtemp_warn_flag_o;
  endproperty
  a_otw: assert property (p_otw)
    else $error("overtemp warning not latched");

  property p_otw_hw;
    @(posedge clk_i) disable iff (reset_i)
      (hw_variant_i && !otw_q) |=> ##1 !overtemp_warn_flag_o;
  endproperty
  a_otw_hw: assert property (p_otw_hw)
    else $error("hardware variant reported overtemp warning");

  property p_overtemp_shutdown_flag;
    @(posedge clk_i) disable iff (reset_i)
      overtemp_shutdown_i |=> (!charge_pump_en_o && gate_pulldown_o == 2'h3);
  endproperty
  a_overtemp_shutdown_flag: assert property (p_overtemp_shutdown_flag)
    else $error("shutdown did not stop pump and pull gates");

  property p_src_gate;
    @(posedge clk_i) disable iff (reset_i)
      !diag_ok |=> (node_pullup_on_o == 2'h0 && node_pulldown_on_o == 2'h0);
  endproperty
  a_src_gate: assert property (p_src_gate)
    else $error("node source on without diagnostic enable");

  property p_ds_live;
    @(posedge clk_i) disable iff (reset_i)
      diag_ok |=> drain_source_flag_o == $past(ds_comparator_i);
  endproperty
  a_ds_live: assert property (p_ds_live)
    else $error("diagnostic status not live");

  property p_pd_off;
    @(posedge clk_i) disable iff (reset_i)
      driver_off_in_i |=> gate_pulldown_o == 2'h3;
  endproperty
  a_pd_off: assert property (p_pd_off)
    else $error("driver off did not pull gates low");

  c_cycle: cover property (@(posedge clk_i) disable iff (reset_i)
    detect[0] && mode_eff == `GTFM_MODE_CYCLE ##[1:20] !active_q[0]);
  c_latch_clr: cover property (@(posedge clk_i) disable iff (reset_i)
    active_q[0] && clr);
  c_overtemp_shutdown_flag: cover property (@(posedge clk_i) disable iff (reset_i)
    $rose(overtemp_shutdown_flag_q));
  c_diag: cover property (@(posedge clk_i) disable iff (reset_i)
    diag_ok && node_pullup_src_en_i != 2'h0);

endmodule

//--- pkg/gtfm_defines.svh
// Constants for the gate and thermal fault manager.
// Assumes a 20 MHz clock and synchronous comparator inputs.
// Contract
// - Gate fault after drive timeout without level
// - Local shutdown choice in modes 00b, 11b
// - Mode field selects gate fault response
// - Latched mode holds fault until clear
// - Cycle mode clears fault on PWM edge
// - Warning mode sets warn and flag only
// - Disabled mode neither reacts nor reports
// - Hardware variant: cycle, 4 us, local, level 6
// - Overtemp warning latched until clear
// - Hardware variant ignores overtemp warning
// - Shutdown pulls gates, stops pump, latches fault
// - Hardware variant recovers after overtemp ends
// - Node sources need diagnostic enable
// - Diagnostics show live comparator state
// - Hardware variant has no offline diagnostics
// - Clear command clears flags, self-resets
`ifndef GTFM_DEFINES_SVH
`define GTFM_DEFINES_SVH
`define GTFM_CLK_MHZ        20
`define GTFM_GATE_DRIVE_TIMEOUT_HW_NS   4000
`define GTFM_GATE_DRIVE_TIMEOUT_HW_CYC  ((`GTFM_GATE_DRIVE_TIMEOUT_HW_NS * `GTFM_CLK_MHZ) / 1000)
`define GTFM_CNT_W          10
`define GTFM_NBR            2
`define GTFM_MODE_LATCH     2'h0
`define GTFM_MODE_CYCLE     2'h1
`define GTFM_MODE_WARN      2'h2
`define GTFM_MODE_DIS       2'h3
`define GTFM_BRG_INDEP      2'h0
`define GTFM_BRG_SPLIT      2'h3
`define GTFM_LVL_GDF_OFF    3'h6
`endif

//--- pkg/gtfm_pkg.sv
// Types for the gate and thermal fault manager.
// Assumes gtfm_defines.svh is included alongside.
package gtfm_pkg;
  typedef enum logic [1:0] {
    GTFM_ST_RUN  = 2'h0,
    GTFM_ST_FLT  = 2'h1,
    GTFM_ST_HOLD = 2'h2
  } gtfm_state_t;
endpackage

//--- tb/gtfm_host_model.sv
// Host model: drives the driver enable and offline diagnostic fields.
// Assumes the bench calls step() in order and checks the device between.
`timescale 1ns/10ps
module gtfm_host_model (
  input  wire logic       clk_i,
  output logic            drv_en_o,
  output logic            diag_en_o,
  output logic [1:0]      pu_o,
  output logic [1:0]      pd_o
);
  // ==========================================================
  // Field state
  initial begin
    drv_en_o  = 1'h1;
    diag_en_o = 1'h0;
    pu_o      = 2'h0;
    pd_o      = 2'h0;
  end

  // ==========================================================
  // One field group per step, so the bench walks the sequence in order
  // Drivers go off before diagnostics and back on after them
  task automatic step(input logic drv, input logic diag,
                      input logic [1:0] pu, input logic [1:0] pd);
    @(posedge clk_i);
    drv_en_o  <= drv;
    diag_en_o <= diag;
    pu_o      <= pu;
    pd_o      <= pd;
    repeat (3) @(posedge clk_i);
    #1;
  endtask
endmodule

//--- tb/test_gtfm_core.sv
// Self-checking bench for the gate and thermal fault manager.
// Assumes gtfm_core, gtfm_pkg and the host model are compiled first.
`timescale 1ns/10ps
`include "gtfm_defines.svh"
module test_gtfm_core;
  // ==========================================================
  // Stimulus and observed signals
  logic       clk_i = 1'h0, reset_i = 1'h1;
  logic       hw = 1'h0, lsd = 1'h0, clr = 1'h0, doff = 1'h0;
  logic       overtemp_warn_flag = 1'h0, overtemp_shutdown_flag = 1'h0;
  logic [2:0] lvl = 3'h0;
  logic [1:0] mode = 2'h0, brg = 2'h0, don = 2'h0, lok = 2'h0;
  logic [1:0] pwm = 2'h0, dsc = 2'h0;
  logic [`GTFM_CNT_W-1:0] tmo = 10'h005;
  logic       drv, diag, fault_n, fsum, wsum, otwf, otsdf, cp, ack;
  logic [1:0] pu, pd, gff, dsf, gpd, puon, pdon;
  int         err_count = 0, num_checks = 0;

  always #25 clk_i = ~clk_i;

  gtfm_host_model i_gtfm_host_model (.clk_i(clk_i), .drv_en_o(drv),
    .diag_en_o(diag), .pu_o(pu), .pd_o(pd));

  gtfm_core i_gtfm_core (.clk_i(clk_i), .reset_i(reset_i),
    .hw_variant_i(hw), .hw_cfg_level_i(lvl), .gate_fault_mode_sel_i(mode),
    .gate_fault_local_shutdown_i(lsd), .bridge_ctrl_mode_i(brg),
    .gate_drive_timeout_i(tmo), .clear_faults_cmd_i(clr),
    .driver_enable_bit_i(drv), .driver_off_in_i(doff),
    .gate_drive_on_i(don), .gate_level_ok_i(lok), .pwm_in_i(pwm),
    .overtemp_warn_i(overtemp_warn_flag), .overtemp_shutdown_i(overtemp_shutdown_flag),
    .offline_diag_enable_i(diag), .node_pullup_src_en_i(pu),
    .node_pulldown_src_en_i(pd), .ds_comparator_i(dsc),
    .fault_out_n_o(fault_n), .fault_summary_o(fsum), .warn_summary_o(wsum),
    .gate_fault_flag_o(gff), .overtemp_warn_flag_o(otwf),
    .overtemp_shutdown_flag_o(otsdf), .drain_source_flag_o(dsf),
    .gate_pulldown_o(gpd), .charge_pump_en_o(cp),
    .node_pullup_on_o(puon), .node_pulldown_on_o(pdon),
    .clear_faults_ack_o(ack));

  // ==========================================================
  // Shared tasks
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic chk(input string nm, input logic [1:0] seen,
                     input logic [1:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Drive one gate for n cycles; its level input stays as the caller set it
  task automatic gf(input int b, input int n);
    @(posedge clk_i);
    don[b] <= 1'h1;
    repeat (n) @(posedge clk_i);
    don[b] <= 1'h0;
    tick(4);
  endtask

  task automatic clear();
    @(posedge clk_i);
    clr <= 1'h1;
    #1 chk("ack", ack, {1'h0, ~hw});
    @(posedge clk_i);
    clr <= 1'h0;
    tick(3);
  endtask

  task automatic close_out();
    $display("Checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    #(50 * 20000);
    err_count++;
    close_out();
  end

  // ==========================================================
  // Tests
  initial begin
    repeat (3) @(posedge clk_i);
    reset_i <= 1'h0;
    tick(2);
    @(posedge clk_i);
    lok <= 2'h1;
    gf(0, 8);
    chk("gff", gff, 2'h0);
    @(posedge clk_i);
    lok <= 2'h0;
    gf(0, 5);
    chk("gff", gff, 2'h0);
    for (int m = 0; m < 4; m++) begin
      @(posedge clk_i);
      mode <= 2'(m);
      gf(0, 8);
      chk("fault_n", fault_n, {1'h0, m > 1});
      chk("gff", gff, {1'h0, m < 3});
      chk("wsum", wsum, {1'h0, m == 2});
      chk("gpd", gpd, (m < 2) ? 2'h3 : 2'h0);
      @(posedge clk_i);
      pwm[0] <= ~pwm[0];
      tick(3);
      chk("fsum", fsum, {1'h0, m == 0});
      chk("gff", gff, {1'h0, m < 3});
      clear();
      chk("gff", gff, 2'h0);
      chk("fault_n", fault_n, 2'h1);
      chk("wsum", wsum, 2'h0);
    end
    @(posedge clk_i);
    mode <= 2'h0;
    lsd  <= 1'h1;
    for (int b = 0; b < 4; b++) begin
      @(posedge clk_i);
      brg <= 2'(b);
      gf(1, 8);
      chk("gpd", gpd, (b == 0 || b == 3) ? 2'h2 : 2'h3);
      clear();
    end
    @(posedge clk_i);
    overtemp_warn_flag <= 1'h1;
    tick(3);
    overtemp_warn_flag <= 1'h0;
    tick(4);
    chk("otwf", otwf, 2'h1);
    chk("wsum", wsum, 2'h1);
    clear();
    chk("otwf", otwf, 2'h0);
    @(posedge clk_i);
    overtemp_shutdown_flag <= 1'h1;
    tick(2);
    overtemp_shutdown_flag <= 1'h0;
    tick(3);
    chk("otsdf", otsdf, 2'h1);
    chk("fault_n", fault_n, 2'h0);
    chk("cp", cp, 2'h0);
    chk("gpd", gpd, 2'h3);
    clear();
    chk("cp", cp, 2'h1);
    @(posedge clk_i);
    doff <= 1'h1;
    tick(3);
    chk("gpd", gpd, 2'h3);
    doff <= 1'h0;
    tick(3);
    chk("gpd", gpd, 2'h0);
    i_gtfm_host_model.step(1'h1, 1'h0, 2'h3, 2'h3);
    chk("puon", puon, 2'h0);
    chk("pdon", pdon, 2'h0);
    i_gtfm_host_model.step(1'h0, 1'h0, 2'h0, 2'h0);
    chk("gpd", gpd, 2'h3);
    i_gtfm_host_model.step(1'h0, 1'h1, 2'h0, 2'h0);
    i_gtfm_host_model.step(1'h0, 1'h1, 2'h1, 2'h2);
    chk("puon", puon, 2'h1);
    chk("pdon", pdon, 2'h2);
    dsc <= 2'h2;
    tick(3);
    chk("dsf", dsf, 2'h2);
    dsc <= 2'h1;
    tick(3);
    chk("dsf", dsf, 2'h1);
    i_gtfm_host_model.step(1'h0, 1'h1, 2'h0, 2'h0);
    chk("puon", puon, 2'h0);
    i_gtfm_host_model.step(1'h0, 1'h0, 2'h0, 2'h0);
    i_gtfm_host_model.step(1'h1, 1'h0, 2'h0, 2'h0);
    chk("gpd", gpd, 2'h0);
    // Fixed-behaviour variant; register fields left at latched settings
    hw  <= 1'h1;
    lsd <= 1'h0;
    brg <= 2'h0;
    tick(2);
    gf(1, `GTFM_GATE_DRIVE_TIMEOUT_HW_CYC);
    chk("gff", gff, 2'h0);
    gf(1, `GTFM_GATE_DRIVE_TIMEOUT_HW_CYC + 3);
    chk("fault_n", fault_n, 2'h0);
    chk("gpd", gpd, 2'h2);
    pwm[1] <= ~pwm[1];
    tick(3);
    chk("fault_n", fault_n, 2'h1);
    clear();
    chk("gff", gff, 2'h2);
    lvl <= 3'h6;
    gf(0, `GTFM_GATE_DRIVE_TIMEOUT_HW_CYC + 3);
    chk("gff", gff, 2'h2);
    chk("fault_n", fault_n, 2'h1);
    overtemp_warn_flag <= 1'h1;
    tick(4);
    chk("otwf", otwf, 2'h0);
    chk("wsum", wsum, 2'h0);
    overtemp_warn_flag  <= 1'h0;
    overtemp_shutdown_flag <= 1'h1;
    tick(3);
    chk("fault_n", fault_n, 2'h0);
    overtemp_shutdown_flag <= 1'h0;
    tick(3);
    chk("fault_n", fault_n, 2'h1);
    chk("cp", cp, 2'h1);
    i_gtfm_host_model.step(1'h0, 1'h1, 2'h3, 2'h3);
    chk("puon", puon, 2'h0);
    chk("pdon", pdon, 2'h0);
    close_out();
  end
endmodule
